// *** src/pio_pkg.sv ***
// constants and register map for the printer sensor and actuator block
package pio_pkg;
    // clock and timing
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PER_US = CLK_HZ / 1_000_000;
    localparam int DEB_TIME_US = 5000;      // head switch settle time
    localparam int DEB_CYC = DEB_TIME_US * CLK_PER_US;
    localparam int ENC_GATE_US = 1000;      // encoder counting window
    localparam int ENC_GATE_CYC = ENC_GATE_US * CLK_PER_US;
    localparam int CAL_TIME_US = 10000;     // ribbon calibration window
    localparam int CAL_CYC = CAL_TIME_US * CLK_PER_US;
    localparam int BRAKE_TIME_US = 20000;   // cutter brake pulse length
    localparam int BRAKE_CYC = BRAKE_TIME_US * CLK_PER_US;
    localparam int CNT_W = 24;              // width of every long timer

    // data widths
    localparam int LEVEL_W = 6;             // 64 sensor levels
    localparam int TH_W = 8;
    localparam int ENC_W = 16;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MEDIA = 8'h08;
    localparam logic [7:0] ADDR_ENC = 8'h0C;
    localparam logic [7:0] ADDR_RIB_TH = 8'h10;
    localparam logic [7:0] ADDR_EVT = 8'h14;
    localparam logic [7:0] ADDR_MASK = 8'h18;

    // control register fields
    localparam int CTRL_MEDIA_SEL = 0;
    localparam int CTRL_CUT_DIR = 1;
    localparam int CTRL_DC_ON = 2;
    localparam int CTRL_DC_DIR = 3;
    localparam int CTRL_CUT_START = 4;      // write one to start, self clearing
    localparam int CTRL_CUT_ABORT = 5;      // write one to stop the cutter
    localparam int CTRL_CAL_START = 6;      // write one to start calibration
    localparam int CTRL_W = 4;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h1;

    // status register fields
    localparam int ST_HEAD_CLOSED = 0;
    localparam int ST_STRIP = 1;
    localparam int ST_RIBBON = 2;
    localparam int ST_CUT_SENSE = 3;
    localparam int ST_ENC = 4;
    localparam int ST_CUT_RUN = 5;
    localparam int ST_CUT_BRAKE = 6;
    localparam int ST_CAL_BUSY = 7;
    localparam int ST_W = 8;

    // media register fields
    localparam int MEDIA_GAP_LSB = 0;
    localparam int MEDIA_MARK_LSB = 8;

    // threshold register fields and reset values
    localparam int TH_LO_LSB = 0;
    localparam int TH_MID_LSB = 8;
    localparam int TH_HI_LSB = 16;
    localparam logic [TH_W-1:0] TH_LO_RST = 8'h40;
    localparam logic [TH_W-1:0] TH_MID_RST = 8'h80;
    localparam logic [TH_W-1:0] TH_HI_RST = 8'hC0;

    // event bits, shared by event and mask registers
    localparam int EV_HEAD = 0;
    localparam int EV_RIBBON = 1;
    localparam int EV_STRIP = 2;
    localparam int EV_CUT_DONE = 3;
    localparam int EV_CAL_DONE = 4;
    localparam int EV_W = 5;
    localparam logic [EV_W-1:0] MASK_RST = 5'h00;

    // cutter sequence; idle to run and run to brake change one bit, brake to idle changes two
    typedef enum logic [1:0] {
        CUT_IDLE = 2'b00,
        CUT_RUN = 2'b01,
        CUT_BRAKE = 2'b11
    } pio_cut_t;
endpackage : pio_pkg

// *** src/pio_brake_if.sv ***
// carrier between cutter sequencer and brake monostable
`timescale 1ns/1ps
interface pio_brake_if;
    logic trigger;   // drive removed, start braking
    logic active;    // brake pulse running
    modport ctl (output trigger, input active);
    modport tmr (input trigger, output active);
endinterface : pio_brake_if

// *** src/pio_sync.sv ***
// two-stage synchroniser for a group of sensor lines
`timescale 1ns/1ps
module pio_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,                  // system clock
    input wire logic srst,                 // synchronous reset
    input wire logic [WIDTH-1:0] din,      // raw sensor level
    output logic [WIDTH-1:0] dout          // level in clock domain
);
    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule : pio_sync

// *** src/pio_brake.sv ***
// retriggerable monostable that brakes the cutter motor
`timescale 1ns/1ps
module pio_brake
    import pio_pkg::*;
#(
    parameter int BRAKE_CYCLES = BRAKE_CYC
) (
    input wire logic clk,       // system clock
    input wire logic srst,      // synchronous reset
    pio_brake_if.tmr brk        // trigger in, active out
);
    logic [CNT_W-1:0] cnt_r;

    // load on trigger, count down to zero
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r <= '0;
        end else if (brk.trigger) begin
            cnt_r <= CNT_W'(BRAKE_CYCLES);
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign brk.active = (cnt_r != '0);
endmodule : pio_brake

// *** src/pio_top.sv ***
// sensor readout and cutter / dc motor control with apb registers
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module pio_top
    import pio_pkg::*;
#(
    parameter int DEB_CYCLES = DEB_CYC,        // head switch settle time
    parameter int ENC_GATE_CYCLES = ENC_GATE_CYC,  // encoder window
    parameter int CAL_CYCLES = CAL_CYC,        // calibration window
    parameter int BRAKE_CYCLES = BRAKE_CYC     // brake pulse length
) (
    input wire logic clk,                      // 40 MHz system clock
    input wire logic srst,                     // synchronous reset
    input wire logic [7:0] paddr,              // apb address
    input wire logic psel,                     // apb select
    input wire logic penable,                  // apb access phase
    input wire logic pwrite,                   // apb direction
    input wire logic [31:0] pwdata,            // apb write data
    output logic [31:0] prdata,                // apb read data
    output logic pready,                       // apb ready
    output logic pslverr,                      // apb error
    input wire logic [LEVEL_W-1:0] gap_level,  // gap sensor reading
    input wire logic [LEVEL_W-1:0] mark_level, // black-mark sensor reading
    input wire logic [TH_W-1:0] ribbon_level,  // ribbon sensor reading
    input wire logic head_closed,              // high when head closed
    input wire logic strip_paper,              // high when paper at strip
    input wire logic ribbon_present,           // high when ribbon seen
    input wire logic cutter_position_sense,    // falls at end of cut
    input wire logic encoder_hole_sense,       // high at gear hole
    output logic media_sensor_select,          // high gap, low black mark
    output logic [TH_W-1:0] ribbon_threshold_setting_lo,  // threshold 1
    output logic [TH_W-1:0] ribbon_threshold_setting_mid, // threshold 2
    output logic [TH_W-1:0] ribbon_threshold_setting_hi,  // threshold 3
    output logic cutter_reset,                 // high once running
    output logic cutter_enable_n,              // low runs cutter
    output logic cutter_direction,             // cutter rotation
    output logic cutter_brake,                 // brake pulse
    output logic dc_motor_switch,              // dc driver on
    output logic dc_motor_direction,           // dc rotation
    output logic irq                           // level interrupt
);
    localparam int N_BITS = 5;
    localparam int N_VEC = 2 * LEVEL_W + TH_W;

    logic [N_BITS-1:0] bits_s;
    logic [N_VEC-1:0] vec_s;
    logic [N_VEC-1:0] vec_prev_r;
    logic [LEVEL_W-1:0] gap_r;
    logic [LEVEL_W-1:0] mark_r;
    logic [TH_W-1:0] rib_lvl_r;
    logic head_s, strip_s, ribbon_s, cut_s, enc_s;
    logic head_deb_r;
    logic [CNT_W-1:0] deb_cnt_r;
    logic strip_prev_r, ribbon_prev_r, cut_prev_r, enc_prev_r;
    logic [CTRL_W-1:0] ctrl_r;
    logic [TH_W-1:0] th_lo_r, th_mid_r, th_hi_r;
    logic [EV_W-1:0] evt_r, mask_r, evt_set, evt_rd_r;
    logic [31:0] rd_nxt;
    logic err_nxt;
    logic setup, wr_acc, rd_acc;
    pio_cut_t cut_st_r;
    logic cut_done;
    logic cal_busy_r, cal_done;
    logic [CNT_W-1:0] cal_cnt_r;
    logic [TH_W-1:0] cal_min_r, cal_max_r;
    logic [CNT_W-1:0] gate_cnt_r;
    logic [ENC_W-1:0] enc_cnt_r, enc_rate_r;

    // the raw lines enter through two flops each
    pio_sync #(.WIDTH(N_BITS)) u_sync_bits (
        .clk(clk),
        .srst(srst),
        .din({head_closed, strip_paper, ribbon_present, cutter_position_sense, encoder_hole_sense}),
        .dout(bits_s)
    );
    pio_sync #(.WIDTH(N_VEC)) u_sync_vec (
        .clk(clk),
        .srst(srst),
        .din({ribbon_level, mark_level, gap_level}),
        .dout(vec_s)
    );

    assign head_s = bits_s[4];
    assign strip_s = bits_s[3];
    assign ribbon_s = bits_s[2];
    assign cut_s = bits_s[1];
    assign enc_s = bits_s[0];

    // multi-bit readings are taken only when two samples agree, so a
    // word caught mid-change never reaches software
    always_ff @(posedge clk) begin
        if (srst) begin
            vec_prev_r <= '0;
            gap_r <= '0;
            mark_r <= '0;
            rib_lvl_r <= '0;
        end else begin
            vec_prev_r <= vec_s;
            if (vec_prev_r == vec_s) begin
                gap_r <= vec_s[LEVEL_W-1:0];
                mark_r <= vec_s[2*LEVEL_W-1:LEVEL_W];
                rib_lvl_r <= vec_s[N_VEC-1:2*LEVEL_W];
            end
        end
    end

    // head switch debounce: accept a new level after it held steady
    always_ff @(posedge clk) begin
        if (srst) begin
            head_deb_r <= 1'b0;
            deb_cnt_r <= '0;
        end else if (head_s == head_deb_r) begin
            deb_cnt_r <= '0;
        end else if (deb_cnt_r >= CNT_W'(DEB_CYCLES - 1)) begin
            head_deb_r <= head_s;
            deb_cnt_r <= '0;
        end else begin
            deb_cnt_r <= deb_cnt_r + 1'b1;
        end
    end

    // previous levels for edge detection
    always_ff @(posedge clk) begin
        if (srst) begin
            strip_prev_r <= 1'b0;
            ribbon_prev_r <= 1'b0;
            cut_prev_r <= 1'b0;
            enc_prev_r <= 1'b0;
        end else begin
            strip_prev_r <= strip_s;
            ribbon_prev_r <= ribbon_s;
            cut_prev_r <= cut_s;
            enc_prev_r <= enc_s;
        end
    end

    // cutter logic leaves reset one edge after the block does
    always_ff @(posedge clk) begin
        if (srst) begin
            cutter_reset <= 1'b0;
        end else begin
            cutter_reset <= 1'b1;
        end
    end

    // apb phases; zero wait states, data latched in the setup cycle
    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign pready = 1'b1;

    // read mux and address check
    always_comb begin
        rd_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        if (paddr == ADDR_CTRL) begin
            rd_nxt[CTRL_W-1:0] = ctrl_r;
        end else if (paddr == ADDR_STATUS) begin
            rd_nxt[ST_HEAD_CLOSED] = head_deb_r;
            rd_nxt[ST_STRIP] = strip_s;
            rd_nxt[ST_RIBBON] = ribbon_s;
            rd_nxt[ST_CUT_SENSE] = cut_s;
            rd_nxt[ST_ENC] = enc_s;
            rd_nxt[ST_CUT_RUN] = (cut_st_r == CUT_RUN);
            rd_nxt[ST_CUT_BRAKE] = (cut_st_r == CUT_BRAKE);
            rd_nxt[ST_CAL_BUSY] = cal_busy_r;
        end else if (paddr == ADDR_MEDIA) begin
            rd_nxt[MEDIA_GAP_LSB +: LEVEL_W] = gap_r;
            rd_nxt[MEDIA_MARK_LSB +: LEVEL_W] = mark_r;
        end else if (paddr == ADDR_ENC) begin
            rd_nxt[ENC_W-1:0] = enc_rate_r;
        end else if (paddr == ADDR_RIB_TH) begin
            rd_nxt[TH_LO_LSB +: TH_W] = th_lo_r;
            rd_nxt[TH_MID_LSB +: TH_W] = th_mid_r;
            rd_nxt[TH_HI_LSB +: TH_W] = th_hi_r;
        end else if (paddr == ADDR_EVT) begin
            rd_nxt[EV_W-1:0] = evt_r;
        end else if (paddr == ADDR_MASK) begin
            rd_nxt[EV_W-1:0] = mask_r;
        end else begin
            err_nxt = 1'b1;
        end
    end

    // read data and error held from setup into the access cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
            evt_rd_r <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            evt_rd_r <= (!pwrite && paddr == ADDR_EVT) ? evt_r : '0;
            pslverr <= err_nxt;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

    // control register: sensor select, directions, dc switch
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_acc && paddr == ADDR_CTRL) begin
            ctrl_r <= pwdata[CTRL_W-1:0];
        end
    end

    assign media_sensor_select = ctrl_r[CTRL_MEDIA_SEL];
    assign cutter_direction = ctrl_r[CTRL_CUT_DIR];
    assign dc_motor_switch = ctrl_r[CTRL_DC_ON];
    assign dc_motor_direction = ctrl_r[CTRL_DC_DIR];

    // cutter sequence: run until the sensor falls, then brake
    pio_brake_if brk_if ();
    pio_brake #(.BRAKE_CYCLES(BRAKE_CYCLES)) u_brake (
        .clk(clk),
        .srst(srst),
        .brk(brk_if.tmr)
    );

    assign cut_done = (cut_st_r == CUT_RUN) && cut_prev_r && !cut_s;

    always_ff @(posedge clk) begin
        if (srst) begin
            cut_st_r <= CUT_IDLE;
        end else begin
            case (cut_st_r)
                CUT_IDLE: begin
                    if (wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_CUT_START]) begin
                        cut_st_r <= CUT_RUN;
                    end
                end
                CUT_RUN: begin
                    if (cut_done || (wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_CUT_ABORT])) begin
                        cut_st_r <= CUT_BRAKE;
                    end
                end
                CUT_BRAKE: begin
                    // back to idle only after the brake pulse ends; a start written meanwhile is dropped
                    if (!brk_if.active && !brk_if.trigger) begin
                        cut_st_r <= CUT_IDLE;
                    end
                end
                default: begin
                    cut_st_r <= CUT_IDLE;
                end
            endcase
        end
    end

    assign brk_if.trigger = (cut_st_r == CUT_RUN) && cut_done
        || (cut_st_r == CUT_RUN) && wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_CUT_ABORT];
    assign cutter_enable_n = (cut_st_r != CUT_RUN);
    assign cutter_brake = brk_if.active;

    // ribbon calibration: track min and max over the window
    always_ff @(posedge clk) begin
        if (srst) begin
            cal_busy_r <= 1'b0;
            cal_cnt_r <= '0;
            cal_min_r <= '1;
            cal_max_r <= '0;
        end else if (!cal_busy_r) begin
            if (wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_CAL_START]) begin
                cal_busy_r <= 1'b1;
                cal_cnt_r <= '0;
                cal_min_r <= '1;
                cal_max_r <= '0;
            end
        end else begin
            cal_cnt_r <= cal_cnt_r + 1'b1;
            if (rib_lvl_r < cal_min_r) begin
                cal_min_r <= rib_lvl_r;
            end
            if (rib_lvl_r > cal_max_r) begin
                cal_max_r <= rib_lvl_r;
            end
            if (cal_done) begin
                cal_busy_r <= 1'b0;
            end
        end
    end

    assign cal_done = cal_busy_r && (cal_cnt_r >= CNT_W'(CAL_CYCLES - 1));

    // thresholds: software write, or calibration result when it ends;
    // a finishing calibration overrides a write in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            th_lo_r <= TH_LO_RST;
            th_mid_r <= TH_MID_RST;
            th_hi_r <= TH_HI_RST;
        end else if (cal_done) begin
            th_lo_r <= cal_min_r;
            th_mid_r <= TH_W'(({1'b0, cal_min_r} + {1'b0, cal_max_r}) >> 1);
            th_hi_r <= cal_max_r;
        end else if (wr_acc && paddr == ADDR_RIB_TH) begin
            th_lo_r <= pwdata[TH_LO_LSB +: TH_W];
            th_mid_r <= pwdata[TH_MID_LSB +: TH_W];
            th_hi_r <= pwdata[TH_HI_LSB +: TH_W];
        end
    end

    assign ribbon_threshold_setting_lo = th_lo_r;
    assign ribbon_threshold_setting_mid = th_mid_r;
    assign ribbon_threshold_setting_hi = th_hi_r;

    // encoder: rising edges per gate window give the rotation rate
    always_ff @(posedge clk) begin
        if (srst) begin
            gate_cnt_r <= '0;
            enc_cnt_r <= '0;
            enc_rate_r <= '0;
        end else if (gate_cnt_r >= CNT_W'(ENC_GATE_CYCLES - 1)) begin
            gate_cnt_r <= '0;
            enc_rate_r <= enc_cnt_r + ENC_W'(enc_s && !enc_prev_r);
            enc_cnt_r <= '0;
        end else begin
            gate_cnt_r <= gate_cnt_r + 1'b1;
            if (enc_s && !enc_prev_r && enc_cnt_r != '1) begin
                enc_cnt_r <= enc_cnt_r + 1'b1;
            end
        end
    end

    // event sources
    logic head_prev_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            head_prev_r <= 1'b0;
        end else begin
            head_prev_r <= head_deb_r;
        end
    end

    always_comb begin
        evt_set = '0;
        evt_set[EV_HEAD] = head_prev_r ^ head_deb_r;
        evt_set[EV_RIBBON] = ribbon_prev_r ^ ribbon_s;
        evt_set[EV_STRIP] = strip_prev_r ^ strip_s;
        evt_set[EV_CUT_DONE] = cut_done;
        evt_set[EV_CAL_DONE] = cal_done;
    end

    // sticky events; a read clears only what it returned, new sets win
    always_ff @(posedge clk) begin
        if (srst) begin
            evt_r <= '0;
        end else if (rd_acc && paddr == ADDR_EVT) begin
            evt_r <= (evt_r & ~evt_rd_r) | evt_set;
        end else begin
            evt_r <= evt_r | evt_set;
        end
    end

    // interrupt mask
    always_ff @(posedge clk) begin
        if (srst) begin
            mask_r <= MASK_RST;
        end else if (wr_acc && paddr == ADDR_MASK) begin
            mask_r <= pwdata[EV_W-1:0];
        end
    end

    assign irq = |(evt_r & mask_r);
endmodule : pio_top

// *** verification/pio_top_sva.sv ***
// port assertions for the printer io block
`timescale 1ns/1ps
module pio_top_sva #(
    parameter int BRAKE_CYCLES = 6
) (
    input wire logic clk, // clock
    input wire logic srst, // sync reset
    input wire logic [7:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb data
    input wire logic cutter_position_sense, // cut sensor
    input wire logic media_sensor_select, // sensor select
    input wire logic cutter_reset, // cutter reset
    input wire logic cutter_enable_n, // cutter run, low
    input wire logic cutter_direction, // cutter dir
    input wire logic cutter_brake, // brake pulse
    input wire logic dc_motor_switch, // dc on
    input wire logic dc_motor_direction // dc dir
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic wr_ctrl;
    logic [23:0] brake_cnt_r;
    // ctrl write lands at the access edge
    assign wr_ctrl = psel && penable && pwrite && paddr == 8'h00;
    // length of the running brake pulse
    always_ff @(posedge clk) begin
        brake_cnt_r <= (srst || !cutter_brake) ? 24'h000000 : brake_cnt_r + 24'h000001;
    end
    a_sel_from_ctrl: assert property (wr_ctrl |=> media_sensor_select == $past(pwdata[0]))
        else $error("media select wrong");
    a_cdir_from_ctrl: assert property (wr_ctrl |=> cutter_direction == $past(pwdata[1]))
        else $error("cutter direction wrong");
    a_dc_on_ctrl: assert property (wr_ctrl |=> dc_motor_switch == $past(pwdata[2]))
        else $error("dc switch wrong");
    a_dc_dir_ctrl: assert property (wr_ctrl |=> dc_motor_direction == $past(pwdata[3]))
        else $error("dc direction wrong");
    a_cut_reset_up: assert property (!$past(srst) |-> cutter_reset)
        else $error("cutter reset low");
    a_run_no_brake: assert property (!cutter_enable_n |-> !cutter_brake)
        else $error("brake while running");
    a_brake_on_stop: assert property ($rose(cutter_brake) |-> $rose(cutter_enable_n))
        else $error("brake without stop");
    a_brake_length: assert property ($fell(cutter_brake) |-> brake_cnt_r == 24'(BRAKE_CYCLES))
        else $error("brake length wrong");
    a_start_runs: assert property (wr_ctrl && pwdata[4] && !pwdata[5] && cutter_enable_n && !cutter_brake
        && !$past(cutter_brake) |=> !cutter_enable_n) else $error("start not taken");
    a_done_stops: assert property (!cutter_enable_n && $fell(cutter_position_sense)
        |-> ##[1:5] cutter_enable_n) else $error("cut not ended");
    c_brake: cover property ($rose(cutter_brake));
    c_cal: cover property (wr_ctrl && pwdata[6]);
    c_done: cover property ($fell(cutter_position_sense));
endmodule : pio_top_sva

bind pio_top pio_top_sva #(.BRAKE_CYCLES(BRAKE_CYCLES)) u_sva (.clk(clk), .srst(srst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .cutter_position_sense(cutter_position_sense),
    .media_sensor_select(media_sensor_select), .cutter_reset(cutter_reset), .cutter_enable_n(cutter_enable_n),
    .cutter_direction(cutter_direction), .cutter_brake(cutter_brake), .dc_motor_switch(dc_motor_switch),
    .dc_motor_direction(dc_motor_direction));

// *** verification/pio_mech_model.sv ***
// mechanism model: cutter position sensor and dc motor encoder
`timescale 1ns/1ps
module pio_mech_model (
    input wire logic clk, // clock
    input wire logic cutter_enable_n, // cutter drive, low runs
    input wire logic dc_motor_switch, // dc driver on
    input wire logic slow, // long cutter stroke
    output logic cutter_position_sense, // falls at stroke end
    output logic encoder_hole_sense // high at gear hole
);
    int stroke = 0;
    logic [1:0] phase = 2'b00;
    initial cutter_position_sense = 1'b1;
    initial encoder_hole_sense = 1'b0;
    // blade moves only while driven; sensor stays low until drive drops
    always @(posedge clk) begin
        stroke <= cutter_enable_n ? 0 : stroke + 1;
        cutter_position_sense <= cutter_enable_n || stroke < (slow ? 12 : 3);
    end
    // a hole passes every four cycles while the motor turns
    always @(posedge clk) begin
        phase <= dc_motor_switch ? phase + 2'b01 : 2'b00;
        encoder_hole_sense <= dc_motor_switch && phase[1];
    end
endmodule : pio_mech_model

// *** verification/tb_top.sv ***
// self-checking bench for the printer io block
`timescale 1ns/1ps
module tb_top
    import pio_pkg::*;
;
    localparam int BRK = 6;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
    logic [7:0] paddr = 8'h00, ribbon_level = 8'h00, th_lo, th_mid, th_hi;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [LEVEL_W-1:0] gap_level = 6'h00, mark_level = 6'h00;
    logic head_closed = 1'b0, strip_paper = 1'b0, ribbon_present = 1'b0, slow = 1'b0;
    logic cps, enc, sel, crst, cen_n, cdir, brake, dcsw, dcdir, irq;
    int n_errors = 0, checked = 0;
    // rows: ctrl nibble written, then {dc dir, dc on, cut dir, select} expected
    logic [7:0] rows [5] = '{8'h00, 8'h55, 8'hAA, 8'h11, 8'hFF};
    always #12.5 clk = ~clk;
    pio_top #(.DEB_CYCLES(8), .ENC_GATE_CYCLES(16), .CAL_CYCLES(8), .BRAKE_CYCLES(BRK)) DUT (.clk(clk),
        .srst(srst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gap_level(gap_level), .mark_level(mark_level),
        .ribbon_level(ribbon_level), .head_closed(head_closed), .strip_paper(strip_paper),
        .ribbon_present(ribbon_present), .cutter_position_sense(cps), .encoder_hole_sense(enc),
        .media_sensor_select(sel), .ribbon_threshold_setting_lo(th_lo), .ribbon_threshold_setting_mid(th_mid),
        .ribbon_threshold_setting_hi(th_hi), .cutter_reset(crst), .cutter_enable_n(cen_n),
        .cutter_direction(cdir), .cutter_brake(brake), .dc_motor_switch(dcsw), .dc_motor_direction(dcdir),
        .irq(irq));
    pio_mech_model u_mech (.clk(clk), .cutter_enable_n(cen_n), .dc_motor_switch(dcsw), .slow(slow),
        .cutter_position_sense(cps), .encoder_hole_sense(enc));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask : chk
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic tally_and_finish();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // watchdog well past the expected few hundred cycles
    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge clk);
        chk("cutter_reset held", 32'h0, {31'h0, crst});
        chk("thresholds reset", 32'h00C08040, {8'h00, th_hi, th_mid, th_lo});
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("cutter_reset up", 32'h1, {31'h0, crst});
        for (int i = 0; i < 5; i++) begin
            apb(ADDR_CTRL, 1'b1, {28'h0, rows[i][7:4]});
            @(posedge clk);
            chk("ctrl outputs", {28'h0, rows[i][3:0]}, {28'h0, dcdir, dcsw, cdir, sel});
        end
        gap_level <= 6'h3F;
        mark_level <= 6'h2A;
        ribbon_level <= 8'h55;
        head_closed <= 1'b1;
        strip_paper <= 1'b1;
        ribbon_present <= 1'b1;
        repeat (40) @(posedge clk);
        apb(ADDR_MEDIA, 1'b0, 32'h0);
        chk("media levels", 32'h00002A3F, q);
        apb(ADDR_STATUS, 1'b0, 32'h0);
        chk("status sensors", 32'h7, q & 32'h7);
        apb(ADDR_ENC, 1'b0, 32'h0);
        chk("encoder count", 32'h4, q);
        apb(ADDR_EVT, 1'b0, 32'h0);
        chk("sensor events", 32'h7, q & 32'h7);
        // a bounce shorter than the settle time must not show
        head_closed <= 1'b0;
        repeat (3) @(posedge clk);
        head_closed <= 1'b1;
        repeat (20) @(posedge clk);
        apb(ADDR_EVT, 1'b0, 32'h0);
        chk("events after bounce", 32'h0, q & 32'h7);
        apb(ADDR_RIB_TH, 1'b1, 32'h00302010);
        @(posedge clk);
        chk("thresholds written", 32'h00302010, {8'h00, th_hi, th_mid, th_lo});
        apb(ADDR_CTRL, 1'b1, 32'h0000004F);
        repeat (20) @(posedge clk);
        chk("thresholds calibrated", 32'h00555555, {8'h00, th_hi, th_mid, th_lo});
        apb(8'h1C, 1'b0, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("pready", 32'h1, {31'h0, pready});
        apb(ADDR_EVT, 1'b0, 32'h0);
        chk("cal done event", 32'h10, q & 32'h10);
        apb(ADDR_MASK, 1'b1, 32'h00000008);
        // slow stroke, then a start refused while braking
        slow <= 1'b1;
        apb(ADDR_CTRL, 1'b1, 32'h0000001F);
        @(posedge clk);
        chk("cutter running", 32'h0, {31'h0, cen_n});
        for (int n = 0; n < 40 && cen_n !== 1'b1; n++) @(posedge clk);
        @(posedge clk);
        chk("brake on", 32'h1, {31'h0, brake});
        chk("irq on cut done", 32'h1, {31'h0, irq});
        apb(ADDR_CTRL, 1'b1, 32'h0000001F);
        @(posedge clk);
        chk("start in brake", 32'h1, {31'h0, cen_n});
        apb(ADDR_EVT, 1'b0, 32'h0);
        chk("cut done event", 32'h8, q & 32'h8);
        @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        repeat (BRK + 4) @(posedge clk);
        chk("brake off", 32'h0, {31'h0, brake});
        apb(ADDR_CTRL, 1'b1, 32'h0000001F);
        apb(ADDR_CTRL, 1'b1, 32'h0000002F);
        @(posedge clk);
        chk("abort brakes", 32'h3, {30'h0, brake, cen_n});
        apb(ADDR_STATUS, 1'b0, 32'h0);
        chk("status brake", 32'h40, q & 32'h60);
        tally_and_finish();
    end
endmodule : tb_top
